/* smfc_defines.svh */
// register map, field positions, reset values and divider figures
`ifndef SMFC_DEFINES_SVH
`define SMFC_DEFINES_SVH

// register byte addresses
`define SMFC_ADDR_RX_DATA      32'h50010700
`define SMFC_ADDR_TX_DATA      32'h50010704
`define SMFC_ADDR_CTRL         32'h50010708
`define SMFC_ADDR_STATUS       32'h5001070C
`define SMFC_ADDR_IRQ_STATUS   32'h50010710
`define SMFC_ADDR_IRQ_ENABLE   32'h50010714
`define SMFC_ADDR_IRQ_CLEAR    32'h50010718

// control register fields
`define SMFC_CTRL_QRST_BIT     24
`define SMFC_CTRL_LOOP_BIT     16
`define SMFC_CTRL_THR_MSB      9
`define SMFC_CTRL_THR_LSB      8
`define SMFC_CTRL_EXT_MSB      7
`define SMFC_CTRL_EXT_LSB      6
`define SMFC_CTRL_CPOL_BIT     5
`define SMFC_CTRL_CPHA_BIT     4
`define SMFC_CTRL_STD_MSB      3
`define SMFC_CTRL_STD_LSB      2
`define SMFC_CTRL_STATE_BIT    1
`define SMFC_CTRL_REQ_BIT      0

// status register fields
`define SMFC_STAT_TXLVL_MSB    17
`define SMFC_STAT_TXLVL_LSB    16
`define SMFC_STAT_RXLVL_MSB    9
`define SMFC_STAT_RXLVL_LSB    8
`define SMFC_STAT_TXFULL_BIT   6
`define SMFC_STAT_TXEMPTY_BIT  5
`define SMFC_STAT_RXFULL_BIT   4
`define SMFC_STAT_RXEMPTY_BIT  3
`define SMFC_STAT_OF_BIT       2
`define SMFC_STAT_UF_BIT       1
`define SMFC_STAT_HIT_BIT      0

// interrupt status, enable and clear fields
`define SMFC_IRQ_MSB           2
`define SMFC_IRQ_OF_BIT        2
`define SMFC_IRQ_UF_BIT        1
`define SMFC_IRQ_HIT_BIT       0

// reset values
`define SMFC_CTRL_RESET        10'h000
`define SMFC_IRQ_EN_RESET      3'h0

// queue geometry
`define SMFC_QUEUE_DEPTH       4
`define SMFC_QUEUE_DEPTH_LVL   3'h4

// serial clock divisors of the system clock
`define SMFC_DIV_0             13'h0002
`define SMFC_DIV_1             13'h0004
`define SMFC_DIV_2             13'h0010
`define SMFC_DIV_3             13'h0020
`define SMFC_DIV_4             13'h0008
`define SMFC_DIV_5             13'h0040
`define SMFC_DIV_6             13'h0080
`define SMFC_DIV_7             13'h0100
`define SMFC_DIV_8             13'h0200
`define SMFC_DIV_9             13'h0400
`define SMFC_DIV_10            13'h0800
`define SMFC_DIV_11            13'h1000

// serial clock edges per byte, last edge index
`define SMFC_LAST_EDGE         4'hF

`endif

/* smfc_pkg.sv */
// types shared by the serial master design
package smfc_pkg;

   // software control fields
   typedef struct packed {
      logic       loopback_select;
      logic [1:0] transfer_irq_threshold;
      logic [1:0] divider_extended_sel;
      logic       cpol;
      logic       cpha;
      logic [1:0] divider_standard_sel;
      logic       enable_request;
   } smfc_ctrl_t;

   // sticky event flags
   typedef struct packed {
      logic tx_queue_overflow;
      logic rx_queue_underflow;
      logic transfer_count_hit;
   } smfc_flags_t;

   // shift engine states
   typedef enum logic [1:0] {
      SMFC_IDLE,
      SMFC_SHIFT,
      SMFC_DONE
   } smfc_state_t;

endpackage : smfc_pkg

/* smfc_spi_master.sv */
// serial master with transmit and receive queues and register port
`timescale 1ns/1ps
`include "smfc_defines.svh"

// What this block does
// - tx data write pushes low byte
// - queue reset bit clears pointers, self-clears
// - loopback picks mosi, else miso
// - threshold code n means n+1 transfers
// - divisor from extended over standard table
// - polarity sets serial clock idle level
// - phase chooses sample and shift edges
// - enable request, separate enable state readback
// - queues usable while interface disabled
// - queued data sent once enabled
// - levels count pushes minus pops
// - full and empty flags, empties set
// - write to full tx flags overflow
// - read of empty rx flags underflow
// - hit flag after threshold transfers
// - masked status, ORed to one line
// - three enables, cleared at reset
// - clear bits drop pending, self-clear
// - rx read returns head, advances
module smfc_spi_master (
   input  wire logic        core_clk_in,   // system clock
   input  wire logic        resetn_in,     // async reset, active low
   input  wire logic [31:0] addr_in,       // register byte address
   input  wire logic [31:0] wdata_in,      // register write data
   input  wire logic        wr_in,         // write strobe
   input  wire logic        rd_in,         // read strobe
   output logic      [31:0] rdata_out,     // read data, cycle after read
   output logic             sclk_out,      // serial clock
   output logic             mosi_out,      // master data out
   input  wire logic        miso_in,       // master data in
   output logic             irq_out        // combined interrupt request
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   smfc_pkg::smfc_ctrl_t  ctrl_reg;
   smfc_pkg::smfc_flags_t flags_reg;
   smfc_pkg::smfc_flags_t flags_set;
   smfc_pkg::smfc_flags_t flags_clr;
   smfc_pkg::smfc_state_t state_reg;
   logic [2:0]  irq_en_reg;
   logic [2:0]  irq_pending;
   logic        enable_state_reg;
   logic [31:0] rdata_reg;
   logic        wr_tx;
   logic        wr_ctrl;
   logic        wr_en;
   logic        wr_clr;
   logic        rd_rx;
   logic        queue_pointer_reset;
   logic        q_push   [0:1];
   logic        q_pop    [0:1];
   logic [7:0]  q_wdata  [0:1];
   logic [7:0]  q_rdata  [0:1];
   logic [2:0]  q_level  [0:1];
   logic        q_full   [0:1];
   logic        q_empty  [0:1];
   logic        miso_meta_reg;
   logic        miso_sync_reg;
   logic        master_in;
   logic [10:0] half_m1;
   logic [10:0] half_cnt_reg;
   logic [3:0]  edge_idx_reg;
   logic        start;
   logic        edge_now;
   logic        leading;
   logic        shift_ev;
   logic        sample_ev;
   logic        sclk_reg;
   logic        mosi_reg;
   logic [7:0]  tx_sh_reg;
   logic [7:0]  rx_sh_reg;
   logic [1:0]  xfer_cnt_reg;
   logic        xfer_done;
   logic        hit_event;
   logic [12:0] divisor;

   ////////////////////////////////////////////////////////////////////////
   // register port decode

   // one strobe per written register and for rx data reads, all in the same cycle as the strobe
   assign wr_tx   = wr_in && (addr_in == `SMFC_ADDR_TX_DATA);
   assign wr_ctrl = wr_in && (addr_in == `SMFC_ADDR_CTRL);
   assign wr_en   = wr_in && (addr_in == `SMFC_ADDR_IRQ_ENABLE);
   assign wr_clr  = wr_in && (addr_in == `SMFC_ADDR_IRQ_CLEAR);
   assign rd_rx   = rd_in && (addr_in == `SMFC_ADDR_RX_DATA);

   // queue reset is a pulse, never stored, so it reads back as zero
   assign queue_pointer_reset = wr_ctrl &&
                                wdata_in[`SMFC_CTRL_QRST_BIT];

   // control fields written by software
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_reg <= `SMFC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg.loopback_select        <= wdata_in[`SMFC_CTRL_LOOP_BIT];
         ctrl_reg.transfer_irq_threshold <=
            wdata_in[`SMFC_CTRL_THR_MSB:`SMFC_CTRL_THR_LSB];
         ctrl_reg.divider_extended_sel   <=
            wdata_in[`SMFC_CTRL_EXT_MSB:`SMFC_CTRL_EXT_LSB];
         ctrl_reg.cpol                   <= wdata_in[`SMFC_CTRL_CPOL_BIT];
         ctrl_reg.cpha                   <= wdata_in[`SMFC_CTRL_CPHA_BIT];
         ctrl_reg.divider_standard_sel   <=
            wdata_in[`SMFC_CTRL_STD_MSB:`SMFC_CTRL_STD_LSB];
         ctrl_reg.enable_request         <= wdata_in[`SMFC_CTRL_REQ_BIT];
      end
   end

   // interrupt enables
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_en_reg <= `SMFC_IRQ_EN_RESET;
      end else if (wr_en) begin
         irq_en_reg <= wdata_in[`SMFC_IRQ_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // queues: entry 0 transmit, entry 1 receive

   // transmit queue fed by software, drained by the shift engine
   assign q_push[0]  = wr_tx && !q_full[0];
   assign q_wdata[0] = wdata_in[7:0];
   assign q_pop[0]   = start;
   // receive queue fed by the shift engine, drained by software
   assign q_push[1]  = xfer_done && !q_full[1];
   assign q_wdata[1] = rx_sh_reg;
   assign q_pop[1]   = rd_rx && !q_empty[1];

   for (genvar q = 0; q < 2; q++) begin : g_queue
      logic [7:0] mem [0:`SMFC_QUEUE_DEPTH-1];
      logic [1:0] wp_reg;
      logic [1:0] rp_reg;
      logic [2:0] lvl_reg;

      // pointers and level, independent of the enable
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            wp_reg  <= 2'h0;
            rp_reg  <= 2'h0;
            lvl_reg <= 3'h0;
         end else if (queue_pointer_reset) begin
            wp_reg  <= 2'h0;
            rp_reg  <= 2'h0;
            lvl_reg <= 3'h0;
         end else begin
            if (q_push[q]) begin
               wp_reg <= wp_reg + 2'h1;
            end
            if (q_pop[q]) begin
               rp_reg <= rp_reg + 2'h1;
            end
            case ({q_push[q], q_pop[q]})
               2'b10:   lvl_reg <= lvl_reg + 3'h1;
               2'b01:   lvl_reg <= lvl_reg - 3'h1;
               default: lvl_reg <= lvl_reg;
            endcase
         end
      end

      // storage, data only
      always_ff @(posedge core_clk_in) begin
         if (q_push[q]) begin
            mem[wp_reg] <= q_wdata[q];
         end
      end

      assign q_rdata[q] = mem[rp_reg];
      assign q_level[q] = lvl_reg;
      assign q_full[q]  = (lvl_reg == `SMFC_QUEUE_DEPTH_LVL);
      assign q_empty[q] = (lvl_reg == 3'h0);
   end

   ////////////////////////////////////////////////////////////////////////
   // serial input synchroniser and loopback

   // two stages before any logic sees the pin
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         miso_meta_reg <= 1'b0;
         miso_sync_reg <= 1'b0;
      end else begin
         miso_meta_reg <= miso_in;
         miso_sync_reg <= miso_meta_reg;
      end
   end

   assign master_in = ctrl_reg.loopback_select ? mosi_reg
                                               : miso_sync_reg;

   ////////////////////////////////////////////////////////////////////////
   // serial clock divider

   // divisor lookup, reserved extended code falls back to the slowest
   always_comb begin
      case ({ctrl_reg.divider_extended_sel,
             ctrl_reg.divider_standard_sel})
         4'h0:    divisor = `SMFC_DIV_0;
         4'h1:    divisor = `SMFC_DIV_1;
         4'h2:    divisor = `SMFC_DIV_2;
         4'h3:    divisor = `SMFC_DIV_3;
         4'h4:    divisor = `SMFC_DIV_4;
         4'h5:    divisor = `SMFC_DIV_5;
         4'h6:    divisor = `SMFC_DIV_6;
         4'h7:    divisor = `SMFC_DIV_7;
         4'h8:    divisor = `SMFC_DIV_8;
         4'h9:    divisor = `SMFC_DIV_9;
         4'hA:    divisor = `SMFC_DIV_10;
         default: divisor = `SMFC_DIV_11;
      endcase
   end

   // half period in system clocks, minus one
   assign half_m1 = divisor[11:1] - 11'h001;

   ////////////////////////////////////////////////////////////////////////
   // shift engine

   // start needs room in the receive queue so no captured byte is lost
   assign start     = (state_reg == smfc_pkg::SMFC_IDLE) &&
                      enable_state_reg && !q_empty[0] &&
                      !q_full[1];
   assign edge_now  = (state_reg == smfc_pkg::SMFC_SHIFT) &&
                      (half_cnt_reg == half_m1);
   assign leading   = !edge_idx_reg[0];
   assign shift_ev  = edge_now && (ctrl_reg.cpha ? leading
                      : (!leading &&
                         edge_idx_reg != `SMFC_LAST_EDGE));
   assign sample_ev = edge_now && (ctrl_reg.cpha ? !leading
                                                 : leading);
   assign xfer_done = (state_reg == smfc_pkg::SMFC_DONE);

   // sequencing: sixteen serial clock edges per byte
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg    <= smfc_pkg::SMFC_IDLE;
         half_cnt_reg <= 11'h000;
         edge_idx_reg <= 4'h0;
      end else begin
         case (state_reg)
            smfc_pkg::SMFC_IDLE: begin
               half_cnt_reg <= 11'h000;
               edge_idx_reg <= 4'h0;
               if (start) begin
                  state_reg <= smfc_pkg::SMFC_SHIFT;
               end
            end
            smfc_pkg::SMFC_SHIFT: begin
               if (edge_now) begin
                  half_cnt_reg <= 11'h000;
                  edge_idx_reg <= edge_idx_reg + 4'h1;
                  if (edge_idx_reg == `SMFC_LAST_EDGE) begin
                     state_reg <= smfc_pkg::SMFC_DONE;
                  end
               end else begin
                  half_cnt_reg <= half_cnt_reg + 11'h001;
               end
            end
            smfc_pkg::SMFC_DONE: begin
               state_reg <= smfc_pkg::SMFC_IDLE;
            end
            default: begin
               state_reg <= smfc_pkg::SMFC_IDLE;
            end
         endcase
      end
   end

   // serial clock rests at the polarity level outside a byte
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sclk_reg <= 1'b0;
      end else if (state_reg != smfc_pkg::SMFC_SHIFT) begin
         sclk_reg <= ctrl_reg.cpol;
      end else if (edge_now) begin
         sclk_reg <= ~sclk_reg;
      end
   end

   // transmit shifter, most significant bit first
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_sh_reg <= 8'h00;
         mosi_reg  <= 1'b0;
      end else if (start) begin
         if (ctrl_reg.cpha) begin
            tx_sh_reg <= q_rdata[0];
         end else begin
            mosi_reg  <= q_rdata[0][7];
            tx_sh_reg <= {q_rdata[0][6:0], 1'b0};
         end
      end else if (shift_ev) begin
         mosi_reg  <= tx_sh_reg[7];
         tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      end
   end

   // receive shifter
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_sh_reg <= 8'h00;
      end else if (sample_ev) begin
         rx_sh_reg <= {rx_sh_reg[6:0], master_in};
      end
   end

   // enable state drops only once the current byte has finished
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         enable_state_reg <= 1'b0;
      end else if (ctrl_reg.enable_request) begin
         enable_state_reg <= 1'b1;
      end else if (state_reg == smfc_pkg::SMFC_IDLE) begin
         enable_state_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transfer counting and event flags

   assign hit_event = xfer_done &&
      (xfer_cnt_reg == ctrl_reg.transfer_irq_threshold);

   // counts completed bytes, wraps at the threshold
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xfer_cnt_reg <= 2'h0;
      end else if (hit_event) begin
         xfer_cnt_reg <= 2'h0;
      end else if (xfer_done) begin
         xfer_cnt_reg <= xfer_cnt_reg + 2'h1;
      end
   end

   // event sources and software clears
   assign flags_set.tx_queue_overflow  = wr_tx && q_full[0];
   assign flags_set.rx_queue_underflow = rd_rx && q_empty[1];
   assign flags_set.transfer_count_hit = hit_event;
   assign flags_clr = wr_clr ? wdata_in[`SMFC_IRQ_MSB:0] : 3'h0;

   // sticky flags, a new event wins over a clear in the same cycle
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flags_reg <= 3'h0;
      end else begin
         flags_reg <= (flags_reg & ~flags_clr) | flags_set;
      end
   end

   assign irq_pending = flags_reg & irq_en_reg;
   assign irq_out     = |irq_pending;

   ////////////////////////////////////////////////////////////////////////
   // read data

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_reg <= 32'h00000000;
      end else if (!rd_in) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= 32'h00000000;
         case (addr_in)
            `SMFC_ADDR_RX_DATA: begin
               if (!q_empty[1]) begin
                  rdata_reg[7:0] <= q_rdata[1];
               end
            end
            `SMFC_ADDR_CTRL: begin
               rdata_reg[`SMFC_CTRL_LOOP_BIT] <= ctrl_reg.loopback_select;
               rdata_reg[`SMFC_CTRL_THR_MSB:`SMFC_CTRL_THR_LSB] <=
                  ctrl_reg.transfer_irq_threshold;
               rdata_reg[`SMFC_CTRL_EXT_MSB:`SMFC_CTRL_EXT_LSB] <=
                  ctrl_reg.divider_extended_sel;
               rdata_reg[`SMFC_CTRL_CPOL_BIT] <= ctrl_reg.cpol;
               rdata_reg[`SMFC_CTRL_CPHA_BIT] <= ctrl_reg.cpha;
               rdata_reg[`SMFC_CTRL_STD_MSB:`SMFC_CTRL_STD_LSB] <=
                  ctrl_reg.divider_standard_sel;
               rdata_reg[`SMFC_CTRL_STATE_BIT] <= enable_state_reg;
               rdata_reg[`SMFC_CTRL_REQ_BIT]   <= ctrl_reg.enable_request;
            end
            `SMFC_ADDR_STATUS: begin
               rdata_reg[`SMFC_STAT_TXLVL_MSB:`SMFC_STAT_TXLVL_LSB] <=
                  q_level[0][1:0];
               rdata_reg[`SMFC_STAT_RXLVL_MSB:`SMFC_STAT_RXLVL_LSB] <=
                  q_level[1][1:0];
               rdata_reg[`SMFC_STAT_TXFULL_BIT]  <= q_full[0];
               rdata_reg[`SMFC_STAT_TXEMPTY_BIT] <= q_empty[0];
               rdata_reg[`SMFC_STAT_RXFULL_BIT]  <= q_full[1];
               rdata_reg[`SMFC_STAT_RXEMPTY_BIT] <= q_empty[1];
               rdata_reg[`SMFC_STAT_OF_BIT]  <=
                  flags_reg.tx_queue_overflow;
               rdata_reg[`SMFC_STAT_UF_BIT]  <=
                  flags_reg.rx_queue_underflow;
               rdata_reg[`SMFC_STAT_HIT_BIT] <=
                  flags_reg.transfer_count_hit;
            end
            `SMFC_ADDR_IRQ_STATUS: begin
               rdata_reg[`SMFC_IRQ_MSB:0] <= irq_pending;
            end
            `SMFC_ADDR_IRQ_ENABLE: begin
               rdata_reg[`SMFC_IRQ_MSB:0] <= irq_en_reg;
            end
            default: begin
               rdata_reg <= 32'h00000000;
            end
         endcase
      end
   end

   assign rdata_out = rdata_reg;
   assign sclk_out  = sclk_reg;
   assign mosi_out  = mosi_reg;

endmodule : smfc_spi_master

/* smfc_spi_master_asserts.sv */
// checker for the register port and interrupt line of the serial master
`timescale 1ns/1ps
`include "smfc_defines.svh"
module smfc_spi_master_asserts (
   input  wire logic        core_clk_in, // clock
   input  wire logic        resetn_in,   // reset, active low
   input  wire logic [31:0] addr_in,     // address
   input  wire logic [31:0] wdata_in,    // write data
   input  wire logic        wr_in,       // write strobe
   input  wire logic        rd_in,       // read strobe
   input  wire logic [31:0] rdata_out,   // read data
   input  wire logic        irq_out      // interrupt
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   logic [2:0] en_reg;
   // mirror of the interrupt enables
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in)
         en_reg <= 3'h0;
      else if (wr_in && addr_in == `SMFC_ADDR_IRQ_ENABLE)
         en_reg <= wdata_in[2:0];
   end
   rdata_idle_a: assert property (
      !$past(rd_in) |-> rdata_out == 32'h0) else $error("stray read data");
   tx_wo_read_a: assert property ($past(rd_in) &&
      $past(addr_in) == `SMFC_ADDR_TX_DATA |-> rdata_out == 32'h0)
      else $error("tx data readable");
   clr_wo_read_a: assert property ($past(rd_in) &&
      $past(addr_in) == `SMFC_ADDR_IRQ_CLEAR |-> rdata_out == 32'h0)
      else $error("irq clear readable");
   reset_bit_a: assert property ($past(rd_in) &&
      $past(addr_in) == `SMFC_ADDR_CTRL |-> rdata_out[31:24] == 8'h0)
      else $error("queue reset bit reads set");
   irq_en_read_a: assert property ($past(rd_in) &&
      $past(addr_in) == `SMFC_ADDR_IRQ_ENABLE |->
      rdata_out == {29'h0, $past(en_reg)}) else $error("enable readback");
   irq_masked_a: assert property ($past(rd_in) &&
      $past(addr_in) == `SMFC_ADDR_IRQ_STATUS |->
      (rdata_out & ~{29'h0, $past(en_reg)}) == 32'h0)
      else $error("unmasked irq status");
   irq_off_a: assert property (en_reg == 3'h0 |-> !irq_out)
      else $error("irq with all sources masked");
   irq_clear_a: assert property (wr_in && wdata_in[2:0] == 3'h7 &&
      addr_in == `SMFC_ADDR_IRQ_CLEAR |=> !irq_out)
      else $error("irq survives clear");
   queue_reset_a: assert property (wr_in && wdata_in[24] &&
      addr_in == `SMFC_ADDR_CTRL ##2 rd_in && addr_in == `SMFC_ADDR_STATUS
      |=> rdata_out[5] && rdata_out[3]) else $error("queues not emptied");
endmodule : smfc_spi_master_asserts
bind smfc_spi_master smfc_spi_master_asserts u_chk (.core_clk_in,
   .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out);

/* smfc_slave_model.sv */
// behavioural serial slave answering one byte per load
`timescale 1ns/1ps
module smfc_slave_model (
   input  wire logic       sclk_in,  // serial clock
   input  wire logic       mosi_in,  // master data
   input  wire logic       cpol_in,  // idle level
   input  wire logic       cpha_in,  // phase
   input  wire logic       load_in,  // arms one byte
   input  wire logic [7:0] reply_in, // byte to send
   output logic            miso_out, // slave data
   output logic      [7:0] got_out   // byte received
);
   logic [7:0] sh_reg = 8'h00;
   int         n      = 0;
   logic       act    = 1'b0;
   // arm a frame with the reply msb on the line
   always @(posedge load_in) begin
      sh_reg = reply_in;
      n = 0;
      act = 1'b1;
   end
   // sample or shift on each serial clock edge, msb first
   always @(sclk_in) begin
      if (act && ((sclk_in != cpol_in) ^ cpha_in)) begin
         got_out = {got_out[6:0], mosi_in};
         n++;
      end else if (act && n > 0)
         sh_reg = {sh_reg[6:0], 1'b0};
      if (n == 8 && sclk_in == cpol_in)
         act = 1'b0;
   end
   // a released line shows the inverse of the shift register msb
   assign miso_out = act ? sh_reg[7] : ~sh_reg[7];
endmodule : smfc_slave_model

/* smfc_spi_master_tb.sv */
// self-checking bench for the serial master
`timescale 1ns/1ps
`include "smfc_defines.svh"
module smfc_spi_master_tb;
   logic        clk, rstn, wr, rd, load, sclk, mosi, miso, irq, cpol, cpha;
   logic [31:0] addr, wdata, rdata;
   logic [7:0]  got, reply;
   int          err_count, comparisons;
   ////////////////////////////////////////////////////////////////////////
   // design and far-side slave
   smfc_spi_master dut (.core_clk_in(clk), .resetn_in(rstn),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .sclk_out(sclk), .mosi_out(mosi),
      .miso_in(miso), .irq_out(irq));
   smfc_slave_model slave (.sclk_in(sclk), .mosi_in(mosi), .cpol_in(cpol),
      .cpha_in(cpha), .load_in(load), .reply_in(reply), .miso_out(miso),
      .got_out(got));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : check
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, e);
   endtask : rd_reg
   // serial clock level a given number of rising system clock edges from now
   task automatic sclk_at(input int n, input logic e);
      repeat (n) @(posedge clk);
      #1 check({31'h0, sclk}, {31'h0, e});
   endtask : sclk_at
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #1_000_000;
      err_count++;
      final_report();
   end
   // register tests, then one byte per clock mode, then loopback
   initial begin
      {rstn, wr, rd, load, cpol, cpha} = 6'h00;
      addr = 32'h0;
      wdata = 32'h0;
      reply = 8'h00;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(`SMFC_ADDR_CTRL, 32'h0);
      rd_reg(`SMFC_ADDR_STATUS, 32'h28);
      rd_reg(`SMFC_ADDR_IRQ_ENABLE, 32'h0);
      rd_reg(32'h5001071C, 32'h0);
      rd_reg(`SMFC_ADDR_TX_DATA, 32'h0);
      rd_reg(`SMFC_ADDR_IRQ_CLEAR, 32'h0);
      wr_reg(`SMFC_ADDR_IRQ_ENABLE, 32'h7);
      for (int i = 0; i < 5; i++)
         wr_reg(`SMFC_ADDR_TX_DATA, 32'hF0 + i);
      rd_reg(`SMFC_ADDR_STATUS, 32'h4C);
      rd_reg(`SMFC_ADDR_IRQ_STATUS, 32'h4);
      wr_reg(`SMFC_ADDR_IRQ_CLEAR, 32'h7);
      check({31'h0, irq}, 32'h0);
      wr_reg(`SMFC_ADDR_CTRL, 32'h0100_0000);
      rd_reg(`SMFC_ADDR_STATUS, 32'h28);
      rd_reg(`SMFC_ADDR_RX_DATA, 32'h0);
      rd_reg(`SMFC_ADDR_STATUS, 32'h2A);
      check({31'h0, irq}, 32'h1);
      wr_reg(`SMFC_ADDR_IRQ_ENABLE, 32'h0);
      check({31'h0, irq}, 32'h0);
      rd_reg(`SMFC_ADDR_IRQ_STATUS, 32'h0);
      wr_reg(`SMFC_ADDR_IRQ_CLEAR, 32'h7);
      for (int m = 0; m < 4; m++) begin
         {cpol, cpha} = m[1:0];
         reply = {m[1:0], 6'h29};
         load = 1'b1;
         #1 load = 1'b0;
         wr_reg(`SMFC_ADDR_TX_DATA, {24'h0, ~m[1:0], 6'h13});
         wr_reg(`SMFC_ADDR_CTRL, {24'h0, 2'b01, m[1:0], 4'h1});
         sclk_at(5, cpol);
         sclk_at(1, ~cpol);
         repeat (80) @(posedge clk);
         check({31'h0, sclk}, {31'h0, cpol});
         rd_reg(`SMFC_ADDR_CTRL, {24'h0, 2'b01, m[1:0], 4'h3});
         rd_reg(`SMFC_ADDR_RX_DATA, {24'h0, m[1:0], 6'h29});
         check({24'h0, got}, {24'h0, ~m[1:0], 6'h13});
         rd_reg(`SMFC_ADDR_STATUS, 32'h29);
         wr_reg(`SMFC_ADDR_CTRL, {24'h0, 2'b01, m[1:0], 4'h0});
         wr_reg(`SMFC_ADDR_IRQ_CLEAR, 32'h1);
      end
      wr_reg(`SMFC_ADDR_CTRL, 32'h0001_0105);
      wr_reg(`SMFC_ADDR_TX_DATA, 32'hA5);
      sclk_at(2, 1'b0);
      sclk_at(1, 1'b1);
      repeat (80) @(posedge clk);
      rd_reg(`SMFC_ADDR_STATUS, 32'h120);
      wr_reg(`SMFC_ADDR_TX_DATA, 32'h3C);
      repeat (80) @(posedge clk);
      rd_reg(`SMFC_ADDR_STATUS, 32'h221);
      rd_reg(`SMFC_ADDR_RX_DATA, 32'hA5);
      rd_reg(`SMFC_ADDR_RX_DATA, 32'h3C);
      final_report();
   end
endmodule : smfc_spi_master_tb
